// ==== rtl/bac_cfg_decode.sv ====
// Registered decode of the raw config bytes into datapath controls
`timescale 1ns/1ns
module bac_cfg_decode
  import bac_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Raw registers
  bac_cfg_if.dst cfg,
  // Decoded controls
  output bac_out_s ctl
);

  // Reset image matches the decode of the register reset values
  localparam bac_out_s BAC_OUT_RST =
      bac_decode_f(BAC_BOOST_RST, BAC_CFGA_RST, BAC_CFGB_RST, BAC_AGC_RST);

  bac_out_s q;
  bac_out_s d;

  // One cycle of decode so every control leaves from a flop
  always_comb begin
    d = bac_decode_f(cfg.boost, cfg.cfga, cfg.cfgb, cfg.agc);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= BAC_OUT_RST;
    end else begin
      q <= d;
    end
  end

  assign ctl = q;

endmodule

// ==== rtl/bac_cfg_if.sv ====
// Raw register bytes passed from the bank to its decoder
`timescale 1ns/1ns
interface bac_cfg_if;
  logic [7:0] boost;
  logic [7:0] cfga;
  logic [7:0] cfgb;
  logic [7:0] agc;
  modport src (output boost, output cfga, output cfgb, output agc);
  modport dst (input boost, input cfga, input cfgb, input agc);
endinterface

// ==== rtl/bac_cfg_regs.sv ====
// Boost, filter, volume and gain-control configuration register bank
`timescale 1ns/1ns
module bac_cfg_regs
  import bac_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Decoded register access from the control port
  input wire logic [BAC_AW-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [BAC_DW-1:0] reg_wdata,
  input wire logic reg_rd,
  output logic [BAC_DW-1:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_hit,
  // Converter and filter controls
  output logic boost_bypass,
  output bac_deci_e decimation_response_sel,
  output logic channel_average_mode,
  output bac_hpf_e highpass_choice,
  output logic highpass_programmable,
  // Volume and biquad controls
  output logic volume_shared,
  output logic [1:0] biquad_count,
  output logic soft_step_on,
  // Automatic gain controls
  output logic auto_gain_master,
  output logic [3:0] auto_gain_target,
  output logic [5:0] target_atten_db,
  output logic [3:0] auto_gain_ceiling,
  output logic [5:0] ceiling_db
);

  bac_regs_s q;
  bac_regs_s d;
  bac_out_s ctl;
  logic [7:0] rd_mux;
  logic rd_known;

  bac_cfg_if cfg_bus ();

  // Read mux sees the stored value, so a same-cycle write reads old data
  always_comb begin
    rd_mux = 8'h00;
    rd_known = 1'b1;
    unique case (reg_addr)
      BAC_BOOST_OFS: rd_mux = q.boost;
      BAC_CFGA_OFS: rd_mux = q.cfga;
      BAC_CFGB_OFS: rd_mux = q.cfgb;
      BAC_AGC_OFS: rd_mux = q.agc;
      default: rd_known = 1'b0;
    endcase
  end

  // Next state of the bank
  always_comb begin
    d = q;
    d.rvalid = reg_rd;
    d.hit = reg_rd && rd_known;
    d.rdata = reg_rd ? rd_mux : 8'h00;
    if (reg_wr) begin
      // Read-only reserved bits are never stored, so they read zero
      unique case (reg_addr)
        BAC_BOOST_OFS: d.boost = reg_wdata & BAC_BOOST_WMASK;
        BAC_CFGA_OFS: d.cfga = reg_wdata & BAC_CFGA_WMASK;
        BAC_CFGB_OFS: d.cfgb = reg_wdata & BAC_CFGB_WMASK;
        BAC_AGC_OFS: d.agc = reg_wdata & BAC_AGC_WMASK;
        default: d.boost = q.boost; // Unmapped writes are dropped
      endcase
    end
  end

  // Bank registers, reset to the documented field values
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q.boost <= BAC_BOOST_RST;
      q.cfga <= BAC_CFGA_RST;
      q.cfgb <= BAC_CFGB_RST;
      q.agc <= BAC_AGC_RST;
      q.rdata <= 8'h00;
      q.rvalid <= 1'b0;
      q.hit <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // Raw bytes to the decoder
  assign cfg_bus.boost = q.boost;
  assign cfg_bus.cfga = q.cfga;
  assign cfg_bus.cfgb = q.cfgb;
  assign cfg_bus.agc = q.agc;

  bac_cfg_decode u_decode (
    .clk(clk),
    .arst_n(arst_n),
    .cfg(cfg_bus.dst),
    .ctl(ctl)
  );

  // Register read answer
  assign reg_rdata = q.rdata;
  assign reg_rvalid = q.rvalid;
  assign reg_hit = q.hit;

  // Decoded controls, each from a decoder flop
  assign boost_bypass = ctl.boost_bypass;
  assign decimation_response_sel = ctl.decimation_response_sel;
  assign channel_average_mode = ctl.channel_average_mode;
  assign highpass_choice = ctl.highpass_choice;
  assign highpass_programmable = ctl.highpass_programmable;
  assign volume_shared = ctl.volume_shared;
  assign biquad_count = ctl.biquad_count;
  assign soft_step_on = ctl.soft_step_on;
  assign auto_gain_master = ctl.auto_gain_master;
  assign auto_gain_target = ctl.auto_gain_target;
  assign target_atten_db = ctl.target_atten_db;
  assign auto_gain_ceiling = ctl.auto_gain_ceiling;
  assign ceiling_db = ctl.ceiling_db;

  // Checks, all in the one clock domain
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // A write to an address, then two edges until the decoded control moves
  sequence s_wr(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence

  chk_boost_bypass: assert property (
    s_wr(BAC_BOOST_OFS) ##1 !reg_wr[*1] |=>
      boost_bypass == $past(reg_wdata[BAC_BYPASS_BIT], 2))
    else $error("boost bypass does not follow bit 7");

  chk_deci_sel: assert property (
    s_wr(BAC_CFGA_OFS) ##1 !reg_wr |=>
      decimation_response_sel == $past(reg_wdata[5:4], 2))
    else $error("decimation response does not follow bits 5-4");

  chk_avg_mode: assert property (
    s_wr(BAC_CFGA_OFS) ##1 !reg_wr |=>
      channel_average_mode == ($past(reg_wdata[3:2], 2) == BAC_SUM_AVG))
    else $error("channel averaging not tied to code 1");

  chk_hpf_prog: assert property (
    s_wr(BAC_CFGA_OFS) ##1 !reg_wr |=>
      highpass_programmable == ($past(reg_wdata[1:0], 2) == BAC_HPF_PROG))
    else $error("programmable high-pass flag not set by code 0");

  chk_hpf_fixed: assert property (
    s_wr(BAC_CFGA_OFS) ##1 !reg_wr |=>
      highpass_choice == $past(reg_wdata[1:0], 2))
    else $error("high-pass choice does not follow bits 1-0");

  chk_vol_shared: assert property (
    s_wr(BAC_CFGB_OFS) ##1 !reg_wr |=>
      volume_shared == $past(reg_wdata[BAC_VOLSH_BIT], 2))
    else $error("volume share does not follow bit 7");

  chk_biquad_cnt: assert property (
    s_wr(BAC_CFGB_OFS) ##1 !reg_wr |=>
      biquad_count == $past(reg_wdata[6:5], 2))
    else $error("biquad count does not follow bits 6-5");

  chk_soft_step: assert property (
    s_wr(BAC_CFGB_OFS) ##1 !reg_wr |=>
      soft_step_on == !$past(reg_wdata[BAC_NOSOFT_BIT], 2))
    else $error("soft stepping not the inverse of bit 4");

  chk_gain_master: assert property (
    $rose(arst_n) |-> auto_gain_master ##0 q.cfgb[BAC_MASTER_BIT])
    else $error("gain master not set out of reset");

  chk_target_db: assert property (
    target_atten_db == 6'(BAC_TGT_BASE_DB
        + BAC_TGT_STEP_DB * int'(auto_gain_target)))
    else $error("target attenuation not 6 dB plus 2 dB per step");

  chk_ceiling_db: assert property (
    auto_gain_ceiling <= BAC_CEIL_MAX_CODE |->
      ceiling_db == 6'(BAC_CEIL_BASE_DB
        + BAC_CEIL_STEP_DB * int'(auto_gain_ceiling)))
    else $error("ceiling not 3 dB plus 3 dB per step");

  chk_reset_vals: assert property (
    $rose(arst_n) |-> q.boost == BAC_BOOST_RST && q.cfga == BAC_CFGA_RST
      && q.cfgb == BAC_CFGB_RST && q.agc == BAC_AGC_RST)
    else $error("register bank not at reset values");

  chk_ro_zero: assert property (
    reg_rd && reg_addr == BAC_CFGB_OFS |=>
      reg_rvalid && reg_hit && reg_rdata[1:0] == 2'h0)
    else $error("read-only reserved bits do not read zero");

  chk_unmapped_read: assert property (
    reg_rd && reg_addr == 8'h6d |=> reg_rvalid && !reg_hit
      && reg_rdata == 8'h00)
    else $error("unmapped read not answered with zero");

  chk_read_back: assert property (
    s_wr(BAC_AGC_OFS) ##1 (reg_rd && reg_addr == BAC_AGC_OFS && !reg_wr)
      |=> reg_rdata == $past(reg_wdata, 2))
    else $error("gain config does not read back as written");

endmodule

// ==== rtl/bac_pkg.sv ====
// Shared constants, types and field decode for the boost and gain config bank
package bac_pkg;

  // Register bus widths
  localparam int BAC_AW = 8;
  localparam int BAC_DW = 8;

  // Register addresses
  localparam logic [7:0] BAC_BOOST_OFS = 8'h6a;
  localparam logic [7:0] BAC_CFGA_OFS = 8'h6b;
  localparam logic [7:0] BAC_CFGB_OFS = 8'h6c;
  localparam logic [7:0] BAC_AGC_OFS = 8'h70;

  // Reset values
  localparam logic [7:0] BAC_BOOST_RST = 8'h00;
  localparam logic [7:0] BAC_CFGA_RST = 8'h01;
  localparam logic [7:0] BAC_CFGB_RST = 8'h48;
  localparam logic [7:0] BAC_AGC_RST = 8'he7;

  // Storable bits; read-only reserved bits are masked off and read zero
  localparam logic [7:0] BAC_BOOST_WMASK = 8'hf8;
  localparam logic [7:0] BAC_CFGA_WMASK = 8'h3f;
  localparam logic [7:0] BAC_CFGB_WMASK = 8'hfc;
  localparam logic [7:0] BAC_AGC_WMASK = 8'hff;

  // Field positions
  localparam int BAC_BYPASS_BIT = 7;
  localparam int BAC_DECI_LSB = 4;
  localparam int BAC_SUM_LSB = 2;
  localparam int BAC_HPF_LSB = 0;
  localparam int BAC_VOLSH_BIT = 7;
  localparam int BAC_BIQ_LSB = 5;
  localparam int BAC_NOSOFT_BIT = 4;
  localparam int BAC_MASTER_BIT = 3;
  localparam int BAC_TGT_LSB = 4;
  localparam int BAC_CEIL_LSB = 0;

  // Level and gain scales in dB
  localparam int BAC_TGT_BASE_DB = 6;
  localparam int BAC_TGT_STEP_DB = 2;
  localparam int BAC_CEIL_BASE_DB = 3;
  localparam int BAC_CEIL_STEP_DB = 3;
  localparam logic [3:0] BAC_CEIL_MAX_CODE = 4'hd;

  // Decimation response codes
  typedef enum logic [1:0] {
    BAC_DECI_LINEAR = 2'h0,
    BAC_DECI_LOW_LAT = 2'h1,
    BAC_DECI_ULTRA_LAT = 2'h2,
    BAC_DECI_BAD = 2'h3
  } bac_deci_e;

  // Channel summation codes
  localparam logic [1:0] BAC_SUM_OFF = 2'h0;
  localparam logic [1:0] BAC_SUM_AVG = 2'h1;

  // High-pass choices
  typedef enum logic [1:0] {
    BAC_HPF_PROG = 2'h0,
    BAC_HPF_FS_0P00025 = 2'h1,
    BAC_HPF_FS_0P002 = 2'h2,
    BAC_HPF_FS_0P008 = 2'h3
  } bac_hpf_e;

  // Decoded configuration as seen by the datapaths
  typedef struct packed {
    logic boost_bypass;
    bac_deci_e decimation_response_sel;
    logic channel_average_mode;
    bac_hpf_e highpass_choice;
    logic highpass_programmable;
    logic volume_shared;
    logic [1:0] biquad_count;
    logic soft_step_on;
    logic auto_gain_master;
    logic [3:0] auto_gain_target;
    logic [5:0] target_atten_db;
    logic [3:0] auto_gain_ceiling;
    logic [5:0] ceiling_db;
  } bac_out_s;

  // Register state of the bank
  typedef struct packed {
    logic [7:0] boost;
    logic [7:0] cfga;
    logic [7:0] cfgb;
    logic [7:0] agc;
    logic [7:0] rdata;
    logic rvalid;
    logic hit;
  } bac_regs_s;

  // Turns raw register bytes into datapath controls
  function automatic bac_out_s bac_decode_f(logic [7:0] boost,
      logic [7:0] cfga, logic [7:0] cfgb, logic [7:0] agc);
    bac_out_s o;
    logic [3:0] ceil;
    o.boost_bypass = boost[BAC_BYPASS_BIT];
    o.decimation_response_sel = bac_deci_e'(cfga[BAC_DECI_LSB +: 2]);
    o.channel_average_mode = (cfga[BAC_SUM_LSB +: 2] == BAC_SUM_AVG);
    o.highpass_choice = bac_hpf_e'(cfga[BAC_HPF_LSB +: 2]);
    o.highpass_programmable = (cfga[BAC_HPF_LSB +: 2] == BAC_HPF_PROG);
    o.volume_shared = cfgb[BAC_VOLSH_BIT];
    o.biquad_count = cfgb[BAC_BIQ_LSB +: 2];
    o.soft_step_on = !cfgb[BAC_NOSOFT_BIT];
    o.auto_gain_master = cfgb[BAC_MASTER_BIT];
    o.auto_gain_target = agc[BAC_TGT_LSB +: 4];
    o.target_atten_db = 6'(BAC_TGT_BASE_DB
        + BAC_TGT_STEP_DB * int'(agc[BAC_TGT_LSB +: 4]));
    o.auto_gain_ceiling = agc[BAC_CEIL_LSB +: 4];
    // Reserved codes are clamped in ceiling_db so it never runs past the top step; auto_gain_ceiling keeps the raw code
    ceil = (agc[BAC_CEIL_LSB +: 4] > BAC_CEIL_MAX_CODE) ?
        BAC_CEIL_MAX_CODE : agc[BAC_CEIL_LSB +: 4];
    o.ceiling_db = 6'(BAC_CEIL_BASE_DB + BAC_CEIL_STEP_DB * int'(ceil));
    return o;
  endfunction

endpackage

// ==== tb/bac_cfg_regs_tb.sv ====
// Self-checking bench for the boost and gain config register bank
`timescale 1ns/1ns
module bac_cfg_regs_tb;
  import bac_pkg::*;
  logic clk, arst_n, reg_wr, reg_rd, reg_rvalid, reg_hit;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, sent;
  logic boost_bypass, channel_average_mode, highpass_programmable;
  logic volume_shared, soft_step_on, auto_gain_master;
  bac_deci_e decimation_response_sel;
  bac_hpf_e highpass_choice;
  logic [1:0] biquad_count;
  logic [3:0] auto_gain_target, auto_gain_ceiling;
  logic [5:0] target_atten_db, ceiling_db;
  logic [9:0] ans;
  logic [7:0] mdl [int];
  logic [7:0] addrs [5];
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;

  bac_cfg_regs bac_cfg_regs_i (.clk(clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_hit(reg_hit), .boost_bypass(boost_bypass),
    .decimation_response_sel(decimation_response_sel),
    .channel_average_mode(channel_average_mode),
    .highpass_choice(highpass_choice),
    .highpass_programmable(highpass_programmable),
    .volume_shared(volume_shared), .biquad_count(biquad_count),
    .soft_step_on(soft_step_on), .auto_gain_master(auto_gain_master),
    .auto_gain_target(auto_gain_target),
    .target_atten_db(target_atten_db),
    .auto_gain_ceiling(auto_gain_ceiling), .ceiling_db(ceiling_db));

  bac_host_model bac_host_model_i (.clk(clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Cut a hang short well past the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("counts: %0d comparisons, %0d mismatches", comparisons,
      fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Decoded controls worked out from the stored bytes
  function automatic logic [31:0] expect_ctl();
    logic [7:0] b, a, c, g;
    logic [3:0] cl;
    b = mdl[8'h6a];
    a = mdl[8'h6b];
    c = mdl[8'h6c];
    g = mdl[8'h70];
    cl = (g[3:0] > 4'hd) ? 4'hd : g[3:0];
    expect_ctl = {b[7], a[5:4], a[3:2] == 2'h1, a[1:0], a[1:0] == 2'h0,
      c[7], c[6:5], ~c[4], c[3], g[7:4], 6'(6 + 2 * int'(g[7:4])),
      g[3:0], 6'(3 + 3 * int'(cl))};
  endfunction

  function automatic logic [31:0] got_ctl();
    got_ctl = {boost_bypass, decimation_response_sel, channel_average_mode,
      highpass_choice, highpass_programmable, volume_shared, biquad_count,
      soft_step_on, auto_gain_master, auto_gain_target, target_atten_db,
      auto_gain_ceiling, ceiling_db};
  endfunction

  // Read one address and compare the answer with the model
  task automatic rd_chk(input logic [7:0] a);
    logic [9:0] exp;
    exp = mdl.exists(int'(a)) ? {2'b11, mdl[int'(a)]} : 10'h200;
    bac_host_model_i.read(a, ans);
    check(32'(ans), 32'(exp));
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bac_host_model_i.write(a, d, sent);
    if (mdl.exists(int'(a))) mdl[int'(a)] = sent;
  endtask

  // Asynchronous reset, released off the clock edge
  task automatic do_reset();
    #3 arst_n = 1'b0;
    mdl[8'h6a] = 8'h00;
    mdl[8'h6b] = 8'h01;
    mdl[8'h6c] = 8'h48;
    mdl[8'h70] = 8'he7;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
  endtask

  task automatic all_chk(input string name);
    foreach (addrs[k]) rd_chk(addrs[k]);
    check(got_ctl(), expect_ctl());
    $display("test %s done", name);
  endtask

  // Main sequence
  initial begin
    arst_n = 1'b0;
    addrs = '{8'h6a, 8'h6b, 8'h6c, 8'h70, 8'h6d};
    void'($urandom(32'hfd14d076));
    do_reset();
    all_chk("reset");
    // Every legal code of every field; the host model clamps reserved ceiling codes to 4'hd
    for (int i = 0; i < 16; i++) begin
      wr(8'h6a, {i[0], 7'h00});
      wr(8'h6b, {2'h0, i[1:0], 1'b0, i[0], i[1:0]});
      wr(8'h6c, {i[0], i[1:0], i[1], 4'h8});
      wr(8'h70, {i[3:0], i[3:0]});
      all_chk("codes");
    end
    // Random data to random places, unmapped ones among them
    for (int i = 0; i < 40; i++) begin
      addrs[4] = 8'($urandom);
      wr(addrs[$urandom_range(0, 4)], 8'($urandom));
      all_chk("random");
    end
    // Back-to-back write and read; the new byte must already read back
    for (int i = 0; i < 4; i++) begin
      bac_host_model_i.write_read(addrs[i], 8'($urandom), sent, ans);
      mdl[int'(addrs[i])] = sent;
      check(32'(ans), 32'({2'b11, mdl[int'(addrs[i])]}));
    end
    all_chk("write read");
    do_reset();
    all_chk("mid reset");
    summarize();
  end
endmodule

// ==== tb/bac_host_model.sv ====
// Host model that drives the config bank's decoded register strobes
`timescale 1ns/1ns
module bac_host_model
  import bac_pkg::*;
(
  // Clock
  input wire logic clk,
  // Register requests
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  // Read answer
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_hit
);
  // Idle at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // Software never leaves reserved bits or codes at other values
  function automatic logic [7:0] legal(input logic [7:0] a,
      input logic [7:0] d);
    legal = d;
    case (a)
      BAC_BOOST_OFS: legal = d & 8'h80;
      BAC_CFGA_OFS: begin
        legal = d & 8'h37;
        if (legal[5:4] == 2'h3) legal[5:4] = 2'h0;
      end
      BAC_CFGB_OFS: legal = (d & 8'hf0) | 8'h08;
      BAC_AGC_OFS: if (d[3:0] > 4'hd) legal[3:0] = 4'hd;
      default: legal = d;
    endcase
  endfunction

  // One-cycle write; released lines show the inverse, not stale data
  task automatic write(input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] sent);
    @(negedge clk);
    sent = legal(a, d);
    reg_addr = a;
    reg_wdata = sent;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~sent;
  endtask

  // One-cycle read; the answer stands in the cycle after the request
  task automatic read(input logic [7:0] a, output logic [9:0] ans);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    ans = {reg_rvalid, reg_hit, reg_rdata};
  endtask

  // Write, then read the same address on the very next edge
  task automatic write_read(input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] sent, output logic [9:0] ans);
    @(negedge clk);
    sent = legal(a, d);
    reg_addr = a;
    reg_wdata = sent;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~sent;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    ans = {reg_rvalid, reg_hit, reg_rdata};
  endtask
endmodule
